// *** sisf_pkg.sv ***
/*
 * sisf_pkg: register offsets, field positions, reset values, timing
 * counts and carrier types for the sensor interrupt status flag block.
 * assumes a single 200 MHz device clock and an 8-bit register port.
 */
package sisf_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SISF_ADDR_FLAGS1   = 8'h00;
	localparam logic [7:0] SISF_ADDR_FLAGS2   = 8'h01;
	localparam logic [7:0] SISF_ADDR_EN1      = 8'h02;
	localparam logic [7:0] SISF_ADDR_EN2      = 8'h03;
	localparam logic [7:0] SISF_ADDR_FIFO_DAT = 8'h07;
	localparam logic [7:0] SISF_ADDR_FIFO_CFG = 8'h08;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SISF_B_NEARLY_FULL = 7;
	localparam int SISF_B_OPTICAL     = 6;
	localparam int SISF_B_AMBIENT     = 5;
	localparam int SISF_B_PROX        = 4;
	localparam int SISF_B_UNDERVOLT   = 0;
	localparam int SISF_B_SUPPLY      = 7;
	localparam int SISF_B_CARDIAC     = 2;
	localparam int SISF_B_AF_CLR      = 6;
	localparam int SISF_THR_W         = 4;

	// ------------------------------------------------------------
	// implemented bits and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SISF_MASK1     = 8'hf1;
	localparam logic [7:0] SISF_MASK2     = 8'h84;
	localparam logic [7:0] SISF_CFG_MASK  = 8'h4f;
	localparam logic [7:0] SISF_RST_FLAGS = 8'h00;
	localparam logic [7:0] SISF_RST_EN    = 8'h00;
	localparam logic [7:0] SISF_RST_CFG   = 8'h0f;

	// ------------------------------------------------------------
	// fifo and timing
	// ------------------------------------------------------------
	localparam int SISF_FIFO_DEPTH = 32;
	localparam int SISF_LVL_W      = 6;
	localparam int SISF_CLK_KHZ    = 200000;
	localparam int SISF_QUAL_MS    = 10;
	localparam int SISF_QUAL_CYC   = SISF_QUAL_MS * SISF_CLK_KHZ;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sisf_req_t;

	typedef struct packed {
		logic push;
		logic alc_overflow;
		logic prox_cross;
		logic cardiac_done;
	} sisf_evt_t;

endpackage : sisf_pkg

// *** sisf_qual.sv ***
/*
 * sisf_qual: qualification timer for a slow condition level.
 * assumes cond is already synchronised to ref_clk; emits one pulse each
 * time the condition has held for QUAL_CYCLES and keeps doing so.
 */
`timescale 1ns/1ps
module sisf_qual #(
	parameter int QUAL_CYCLES = 2000000
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// condition and result
	input  wire logic cond,
	output logic      hit
);

	localparam int CW = $clog2(QUAL_CYCLES + 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_hit;

	always_comb begin
		next_cnt = '0;
		next_hit = 1'b0;
		if (cond) begin
			if (cnt == CW'(QUAL_CYCLES - 1)) begin
				next_hit = 1'b1;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
			hit <= 1'b0;
		end else begin
			cnt <= next_cnt;
			hit <= next_hit;
		end
	end

endmodule : sisf_qual

// *** sisf_flags.sv ***
/*
 * sisf_flags: interrupt status flags, enables and almost-full settings
 * of the optical and cardiac sensor, with the proximity sequencer.
 * assumes an internal register port on ref_clk (read data one cycle
 * after the strobe) and event pulses from logic on the same clock;
 * the two supply comparator pins are asynchronous.
 */
// Behaviour
// (RQ1) set nearly-full when next push crosses threshold
// (RQ2) nearly-full clears on flags1 read, optionally data
// (RQ3) optical ready sets on push while measuring
// (RQ4) optical ready clears on flags1 or data read
// (RQ5) ambient overflow sets when cancellation saturates
// (RQ6) ambient overflow clears only on flags1 read
// (RQ7) proximity disabled: start optical measurement immediately
// (RQ8) proximity crossing sets flag; flags1 read clears
// (RQ9) undervoltage sets on low battery; not soft reset
// (RQ10) supply flag after 10 ms, re-set while persisting
// (RQ11) supply flag clears on flags2 read
// (RQ12) cardiac ready sets on conversion done
// (RQ13) each flag has enable, reset zero, gating
// (RQ14) interrupt low while any enabled flag set
// (RQ15) cardiac clears on flags2 read; set wins
// (RQ16) status registers ignore writes, unused bits zero
`timescale 1ns/1ps
module sisf_flags import sisf_pkg::*; #(
	parameter int QUAL_CYCLES = SISF_QUAL_CYC,
	parameter int FIFO_DEPTH  = SISF_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rstn,
	// register port
	input  wire sisf_req_t             req,
	output logic [7:0]                 rd_data,
	// internal events
	input  wire sisf_evt_t             evt,
	input  wire logic [SISF_LVL_W-1:0] fifo_level,
	input  wire logic                  optical_active,
	input  wire logic                  meas_request,
	input  wire logic                  meas_stop,
	input  wire logic                  soft_reset,
	// asynchronous supply comparators
	input  wire logic                  battery_low_pin,
	input  wire logic                  supply_oor_pin,
	// outputs
	output logic                       irq_n,
	output logic                       prox_mode,
	output logic                       optical_run
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic rd_at(input sisf_req_t r, input logic [7:0] a);
		return r.rd && (r.addr == a);
	endfunction : rd_at

	function automatic logic wr_at(input sisf_req_t r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction : wr_at

	logic rd_f1;
	logic rd_f2;
	logic rd_dat;
	assign rd_f1  = rd_at(req, SISF_ADDR_FLAGS1);
	assign rd_f2  = rd_at(req, SISF_ADDR_FLAGS2);
	assign rd_dat = rd_at(req, SISF_ADDR_FIFO_DAT);

	// ------------------------------------------------------------
	// supply pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] bat_sync;
	logic [1:0] oor_sync;
	logic       bat_prev;
	logic       oor_hit;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bat_sync <= 2'h0;
			oor_sync <= 2'h0;
			bat_prev <= 1'b0;
		end else begin
			bat_sync <= {bat_sync[0], battery_low_pin};
			oor_sync <= {oor_sync[0], supply_oor_pin};
			bat_prev <= bat_sync[1];
		end
	end

	sisf_qual #(
		.QUAL_CYCLES (QUAL_CYCLES)
	) u_qual (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.cond    (oor_sync[1]),
		.hit     (oor_hit)
	);

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0] en1;
	logic [7:0] en2;
	logic [7:0] cfg;
	logic [7:0] next_en1;
	logic [7:0] next_en2;
	logic [7:0] next_cfg;

	always_comb begin
		next_en1 = en1;
		next_en2 = en2;
		next_cfg = cfg;
		if (soft_reset) begin
			next_en1 = SISF_RST_EN;
			next_en2 = SISF_RST_EN;
			next_cfg = SISF_RST_CFG;
		end else begin
			if (wr_at(req, SISF_ADDR_EN1))
				next_en1 = req.wdata & SISF_MASK1; // RQ13
			if (wr_at(req, SISF_ADDR_EN2))
				next_en2 = req.wdata & SISF_MASK2; // RQ13
			if (wr_at(req, SISF_ADDR_FIFO_CFG))
				next_cfg = req.wdata & SISF_CFG_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			en1 <= SISF_RST_EN;
			en2 <= SISF_RST_EN;
			cfg <= SISF_RST_CFG;
		end else begin
			en1 <= next_en1;
			en2 <= next_en2;
			cfg <= next_cfg;
		end
	end

	// ------------------------------------------------------------
	// proximity sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SISF_IDLE,
		SISF_PROX,
		SISF_MEAS
	} sisf_state_t;

	sisf_state_t state;
	sisf_state_t next_state;
	logic        prox_hit;

	assign prox_hit = (state == SISF_PROX) && evt.prox_cross;

	always_comb begin
		next_state = state;
		case (state)
			SISF_IDLE: begin
				if (meas_request)
					next_state = en1[SISF_B_PROX] ? SISF_PROX : SISF_MEAS; // RQ7
			end
			SISF_PROX: begin
				if (meas_stop)
					next_state = SISF_IDLE;
				else if (prox_hit || !en1[SISF_B_PROX])
					next_state = SISF_MEAS;
			end
			SISF_MEAS: begin
				if (meas_stop)
					next_state = SISF_IDLE;
			end
			default: next_state = SISF_IDLE;
		endcase
		if (soft_reset)
			next_state = SISF_IDLE;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state       <= SISF_IDLE;
			prox_mode   <= 1'b0;
			optical_run <= 1'b0;
		end else begin
			state       <= next_state;
			prox_mode   <= (next_state == SISF_PROX);
			optical_run <= (next_state == SISF_MEAS);
		end
	end

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	logic [7:0]            flags1;
	logic [7:0]            flags2;
	logic [7:0]            next_flags1;
	logic [7:0]            next_flags2;
	logic [7:0]            set1;
	logic [7:0]            set2;
	logic [7:0]            clr1;
	logic [7:0]            clr2;
	logic [SISF_LVL_W:0]   lvl_after;
	logic [SISF_LVL_W:0]   af_mark;
	logic                  af_hit;

	always_comb begin
		lvl_after = {1'b0, fifo_level} + 1'b1;
		af_mark   = (SISF_LVL_W + 1)'(FIFO_DEPTH) - {3'h0, cfg[SISF_THR_W-1:0]};
		af_hit    = evt.push && (lvl_after >= af_mark); // RQ1
		set1 = 8'h00;
		set1[SISF_B_NEARLY_FULL] = af_hit; // RQ1
		set1[SISF_B_OPTICAL]     = evt.push && optical_active; // RQ3
		set1[SISF_B_AMBIENT]     = evt.alc_overflow; // RQ5
		set1[SISF_B_PROX]        = prox_hit; // RQ8
		set1[SISF_B_UNDERVOLT]   = bat_sync[1] && !bat_prev; // RQ9
		set2 = 8'h00;
		set2[SISF_B_SUPPLY]      = oor_hit; // RQ10
		set2[SISF_B_CARDIAC]     = evt.cardiac_done; // RQ12
		clr1 = rd_f1 ? 8'hff : 8'h00; // RQ2 RQ4 RQ6 RQ8 RQ9
		if (rd_dat) begin
			clr1[SISF_B_OPTICAL] = 1'b1; // RQ4
			if (cfg[SISF_B_AF_CLR])
				clr1[SISF_B_NEARLY_FULL] = 1'b1; // RQ2
		end
		clr2 = rd_f2 ? 8'hff : 8'h00; // RQ11 RQ15
		// set wins over clear; writes never reach the flags
		next_flags1 = ((flags1 & ~clr1) | set1) & SISF_MASK1; // RQ16
		next_flags2 = ((flags2 & ~clr2) | set2) & SISF_MASK2; // RQ15 RQ16
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			flags1 <= SISF_RST_FLAGS;
			flags2 <= SISF_RST_FLAGS;
		end else begin
			flags1 <= next_flags1;
			flags2 <= next_flags2;
		end
	end

	// ------------------------------------------------------------
	// read data and interrupt
	// ------------------------------------------------------------
	logic [7:0] next_rd_data;
	logic       next_irq_n;

	always_comb begin
		next_rd_data = 8'h00;
		if (req.rd) begin
			case (req.addr)
				SISF_ADDR_FLAGS1:   next_rd_data = flags1 & SISF_MASK1; // RQ16
				SISF_ADDR_FLAGS2:   next_rd_data = flags2 & SISF_MASK2; // RQ16
				SISF_ADDR_EN1:      next_rd_data = en1;
				SISF_ADDR_EN2:      next_rd_data = en2;
				SISF_ADDR_FIFO_CFG: next_rd_data = cfg;
				default:            next_rd_data = 8'h00;
			endcase
		end
		next_irq_n = ~(|(flags1 & en1) | |(flags2 & en2)); // RQ13 RQ14
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= 8'h00;
			irq_n   <= 1'b1;
		end else begin
			rd_data <= next_rd_data;
			irq_n   <= next_irq_n;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_nearly_full_set: assert property ( // RQ1
		@(posedge ref_clk) disable iff (!rstn)
		af_hit |=> flags1[SISF_B_NEARLY_FULL]
	) else $error("nearly-full not set on threshold push");

	a_nearly_full_hold: assert property ( // RQ2
		@(posedge ref_clk) disable iff (!rstn)
		rd_dat && !rd_f1 && !cfg[SISF_B_AF_CLR] && flags1[SISF_B_NEARLY_FULL]
		|=> flags1[SISF_B_NEARLY_FULL]
	) else $error("nearly-full cleared by data read with option off");

	a_optical_set: assert property ( // RQ3
		@(posedge ref_clk) disable iff (!rstn)
		evt.push && optical_active |=> flags1[SISF_B_OPTICAL]
	) else $error("optical ready not set on push");

	a_optical_clear: assert property ( // RQ4
		@(posedge ref_clk) disable iff (!rstn)
		rd_dat && !(evt.push && optical_active) |=> !flags1[SISF_B_OPTICAL]
	) else $error("optical ready not cleared by data read");

	a_ambient_keep: assert property ( // RQ6
		@(posedge ref_clk) disable iff (!rstn)
		rd_dat && !rd_f1 && flags1[SISF_B_AMBIENT] |=> flags1[SISF_B_AMBIENT]
	) else $error("ambient overflow cleared by data read");

	a_prox_skip: assert property ( // RQ7
		@(posedge ref_clk) disable iff (!rstn)
		state == SISF_IDLE && meas_request && !en1[SISF_B_PROX] && !soft_reset
		|=> optical_run && !prox_mode
	) else $error("measurement did not start at once");

	a_undervolt_clear: assert property ( // RQ9
		@(posedge ref_clk) disable iff (!rstn)
		rd_f1 && !(bat_sync[1] && !bat_prev) |=> !flags1[SISF_B_UNDERVOLT]
	) else $error("undervoltage flag not cleared by read");

	a_supply_set: assert property ( // RQ10
		@(posedge ref_clk) disable iff (!rstn)
		$rose(oor_sync[1]) ##1 oor_sync[1] [*8] |-> !flags2[SISF_B_SUPPLY] || $past(flags2[SISF_B_SUPPLY], 9)
		|| QUAL_CYCLES <= 9
	) else $error("supply flag set before qualification");

	a_cardiac_set: assert property ( // RQ15
		@(posedge ref_clk) disable iff (!rstn)
		evt.cardiac_done && rd_f2 |=> flags2[SISF_B_CARDIAC]
	) else $error("cardiac event lost on clearing read");

	a_irq_follow: assert property ( // RQ14
		@(posedge ref_clk) disable iff (!rstn)
		(|(flags1 & en1) || |(flags2 & en2)) |=> !irq_n
	) else $error("interrupt not driven for enabled flag");

	a_unused_zero: assert property ( // RQ16
		@(posedge ref_clk) disable iff (!rstn)
		rd_f1 |=> (rd_data & ~SISF_MASK1) == 8'h00
	) else $error("unused status bits read nonzero");

endmodule : sisf_flags

// *** sisf_host.sv ***
/*
 * sisf_host: host processor model on the register port of the flag block.
 * assumes ref_clk is the device clock; the bench calls access() to run cycles.
 */
`timescale 1ns/1ps
module sisf_host import sisf_pkg::*; (
	// clock
	input  wire logic       ref_clk,
	// register port
	output sisf_req_t       req,
	input  wire logic [7:0] rd_data
);
	initial req = '0;

	// ------------------------------------------------------------
	// one access: strobe held one cycle, read data taken on the falling edge after it
	// ------------------------------------------------------------
	task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] q);
		@(posedge ref_clk);
		req <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
		@(posedge ref_clk);
		req <= '0;
		@(negedge ref_clk);
		q = rd_data;
	endtask : access
endmodule : sisf_host

// *** sensor_interrupt_status_flags_test.sv ***
/*
 * sensor_interrupt_status_flags_test: self-checking bench of the flag block.
 * assumes sisf_host drives the register port; short qualification count.
 */
`timescale 1ns/1ps
module sensor_interrupt_status_flags_test import sisf_pkg::*;;
	typedef struct packed {
		sisf_evt_t  e;
		logic       opt;
		logic [5:0] lvl;
		logic [7:0] addr;
		logic [7:0] exp;
	} sisf_row_t;

	logic                  ref_clk, rstn, optical_active, meas_request, meas_stop, soft_reset;
	logic                  battery_low_pin, supply_oor_pin, irq_n, prox_mode, optical_run;
	sisf_req_t             req;
	sisf_evt_t             evt;
	logic [7:0]            rd_data, v;
	logic [SISF_LVL_W-1:0] fifo_level;
	int                    n_fail, n_tests;
	sisf_row_t             rows [5] = '{
		'{4'h8, 1'b1, 6'h00, 8'h00, 8'h40},
		'{4'h8, 1'b0, 6'h10, 8'h00, 8'h80},
		'{4'h8, 1'b0, 6'h0f, 8'h00, 8'h00},
		'{4'h4, 1'b0, 6'h00, 8'h00, 8'h20},
		'{4'h1, 1'b0, 6'h00, 8'h01, 8'h04}};

	sisf_flags #(.QUAL_CYCLES(20), .FIFO_DEPTH(32)) sisf_flags_i (.ref_clk(ref_clk),
		.rstn(rstn), .req(req), .rd_data(rd_data), .evt(evt), .fifo_level(fifo_level),
		.optical_active(optical_active), .meas_request(meas_request), .meas_stop(meas_stop),
		.soft_reset(soft_reset), .battery_low_pin(battery_low_pin),
		.supply_oor_pin(supply_oor_pin), .irq_n(irq_n), .prox_mode(prox_mode),
		.optical_run(optical_run));
	sisf_host sisf_host_i (.ref_clk(ref_clk), .req(req), .rd_data(rd_data));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic rd(input logic [7:0] a);
		sisf_host_i.access(1'b1, a, 8'h00, v);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		sisf_host_i.access(1'b0, a, d, q);
	endtask : wr

	task automatic pulse(input sisf_evt_t e, input logic opt, input logic [5:0] lvl);
		@(posedge ref_clk);
		evt <= e;
		optical_active <= opt;
		fifo_level <= lvl;
		@(posedge ref_clk);
		evt <= '0;
	endtask : pulse

	// bit 2 request, bit 1 stop, bit 0 soft reset
	task automatic ctl(input logic [2:0] c);
		@(posedge ref_clk);
		{meas_request, meas_stop, soft_reset} <= c;
		@(posedge ref_clk);
		{meas_request, meas_stop, soft_reset} <= 3'h0;
		@(negedge ref_clk);
	endtask : ctl

	task automatic wait_irq(input logic lvl);
		for (int n = 0; n < 8; n++) begin
			@(negedge ref_clk);
			if (irq_n === lvl)
				break;
		end
		check("irq_n", {7'h00, irq_n}, {7'h00, lvl});
		if (irq_n !== lvl)
			stop_test();
	endtask : wait_irq

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		$display("mismatch timeout expected done seen hang");
		stop_test();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rstn, optical_active, meas_request, meas_stop, soft_reset} = 5'h00;
		{battery_low_pin, supply_oor_pin} = 2'h0;
		evt = '0;
		fifo_level = '0;
		n_fail = 0;
		n_tests = 0;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		check("irq_n reset", {7'h00, irq_n}, 8'h01);
		check("seq reset", {6'h00, prox_mode, optical_run}, 8'h00);
		for (int a = 0; a < 4; a++) begin
			rd(a[7:0]);
			check("reset reg", v, 8'h00);
		end
		rd(SISF_ADDR_FIFO_CFG);
		check("cfg reset", v, 8'h0f);
		foreach (rows[i]) begin
			pulse(rows[i].e, rows[i].opt, rows[i].lvl);
			rd(rows[i].addr);
			check("row flags", v, rows[i].exp);
			rd(rows[i].addr);
			check("row cleared", v, 8'h00);
		end
		// data read clears optical always, and nearly-full only while clear option is on
		pulse(4'hc, 1'b1, 6'h10);
		rd(SISF_ADDR_FIFO_DAT);
		rd(SISF_ADDR_FLAGS1);
		check("data read", v, 8'ha0);
		wr(SISF_ADDR_FIFO_CFG, 8'h4f);
		pulse(4'h8, 1'b0, 6'h10);
		rd(SISF_ADDR_FIFO_DAT);
		rd(SISF_ADDR_FLAGS1);
		check("data read clr", v, 8'h00);
		wr(SISF_ADDR_FIFO_CFG, 8'h04);
		pulse(4'h8, 1'b0, 6'h1b);
		rd(SISF_ADDR_FLAGS1);
		check("threshold hit", v, 8'h80);
		pulse(4'h8, 1'b0, 6'h1a);
		rd(SISF_ADDR_FLAGS1);
		check("threshold miss", v, 8'h00);
		pulse(4'h4, 1'b0, 6'h00);
		wr(SISF_ADDR_FLAGS1, 8'hff);
		rd(SISF_ADDR_FLAGS1);
		check("status write", v, 8'h20);
		// only enabled flags pull the interrupt low
		wr(SISF_ADDR_EN1, 8'h20);
		pulse(4'h1, 1'b0, 6'h00);
		repeat (4) @(negedge ref_clk);
		check("irq masked", {7'h00, irq_n}, 8'h01);
		pulse(4'h4, 1'b0, 6'h00);
		wait_irq(1'b0);
		rd(SISF_ADDR_FLAGS2);
		rd(SISF_ADDR_FLAGS1);
		wait_irq(1'b1);
		// second enable register keeps only its implemented bits
		wr(SISF_ADDR_EN2, 8'hff);
		rd(SISF_ADDR_EN2);
		check("enable2 bits", v, 8'h84);
		pulse(4'h1, 1'b0, 6'h00);
		wait_irq(1'b0);
		rd(SISF_ADDR_FLAGS2);
		wait_irq(1'b1);
		wr(SISF_ADDR_EN2, 8'h00);
		// proximity sequencing
		wr(SISF_ADDR_EN1, 8'h10);
		ctl(3'h4);
		check("prox mode", {6'h00, prox_mode, optical_run}, 8'h02);
		pulse(4'h2, 1'b0, 6'h00);
		repeat (2) @(negedge ref_clk);
		check("prox to run", {6'h00, prox_mode, optical_run}, 8'h01);
		rd(SISF_ADDR_FLAGS1);
		check("prox flag", v, 8'h10);
		ctl(3'h2);
		pulse(4'h2, 1'b0, 6'h00);
		rd(SISF_ADDR_FLAGS1);
		check("prox idle", v, 8'h00);
		ctl(3'h4);
		ctl(3'h2);
		check("prox stop", {6'h00, prox_mode, optical_run}, 8'h00);
		ctl(3'h4);
		wr(SISF_ADDR_EN1, 8'h00);
		repeat (2) @(negedge ref_clk);
		check("prox masked", {6'h00, prox_mode, optical_run}, 8'h01);
		ctl(3'h2);
		ctl(3'h4);
		check("prox skipped", {6'h00, prox_mode, optical_run}, 8'h01);
		ctl(3'h2);
		// undervoltage on the battery comparator, not on soft reset
		@(posedge ref_clk) battery_low_pin <= 1'b1;
		repeat (5) @(negedge ref_clk);
		rd(SISF_ADDR_FLAGS1);
		check("undervolt", v, 8'h01);
		rd(SISF_ADDR_FLAGS1);
		check("undervolt clr", v, 8'h00);
		@(posedge ref_clk) battery_low_pin <= 1'b0;
		ctl(3'h1);
		rd(SISF_ADDR_FLAGS1);
		check("soft reset", v, 8'h00);
		// supply qualification and repeat while the condition lasts
		@(posedge ref_clk) supply_oor_pin <= 1'b1;
		repeat (25) @(negedge ref_clk);
		rd(SISF_ADDR_FLAGS2);
		check("supply set", v, 8'h80);
		rd(SISF_ADDR_FLAGS2);
		check("supply clr", v, 8'h00);
		repeat (20) @(negedge ref_clk);
		rd(SISF_ADDR_FLAGS2);
		check("supply again", v, 8'h80);
		@(posedge ref_clk) supply_oor_pin <= 1'b0;
		// event in the cycle of its clearing read keeps the flag
		fork
			rd(SISF_ADDR_FLAGS2);
			pulse(4'h1, 1'b0, 6'h00);
		join
		rd(SISF_ADDR_FLAGS2);
		check("set wins", v, 8'h04);
		rd(SISF_ADDR_FLAGS2);
		check("cardiac clr", v, 8'h00);
		stop_test();
	end
endmodule : sensor_interrupt_status_flags_test
